//--- src/lsr_pkg.sv
// Purpose: Shared constants for the live status and result register group.
// Assumes: 8-bit register index, 16-bit register data, 10 MHz core clock.
// Notes: Offsets are register indices on the serial port, not byte addresses.
`default_nettype none
package lsr_pkg;
    // Register indices
    localparam logic [7:0] LSR_ADDR_LIVE = 8'h42;
    localparam logic [7:0] LSR_ADDR_RES1 = 8'h44;
    localparam logic [7:0] LSR_ADDR_RES2 = 8'h46;
    localparam logic [7:0] LSR_ADDR_DIAG0 = 8'h53;
    localparam logic [7:0] LSR_ADDR_DIAG3 = 8'h56;
    localparam logic [7:0] LSR_ADDR_COUNT = 8'h57;

    // Live condition word bit positions
    localparam int unsigned LSR_BIT_ANA_OPEN = 14;
    localparam int unsigned LSR_BIT_ANA_SHORT = 13;
    localparam int unsigned LSR_BIT_OUT_INT_SHORT = 10;
    localparam int unsigned LSR_BIT_OUT_EXT_SHORT = 9;
    localparam int unsigned LSR_BIT_OUT_THERM = 8;
    localparam int unsigned LSR_BIT_IN_OPEN = 7;
    localparam int unsigned LSR_BIT_IN_SHORT = 6;
    localparam int unsigned LSR_BIT_TEMP = 4;
    localparam int unsigned LSR_BIT_DATA_RDY = 3;
    localparam int unsigned LSR_BIT_BUSY = 2;
    localparam int unsigned LSR_BIT_SUPPLY = 1;

    // Reset values
    localparam logic [15:0] LSR_RESULT_RESET = 16'h0000;
    localparam logic [15:0] LSR_COUNT_RESET = 16'h0000;
    localparam logic LSR_BUSY_RESET = 1'b1;

    // Die temperature alert threshold in degrees C
    localparam int LSR_TEMP_HIGH_C = 115;

    // Conversion-ready pin low time: 24 us at the core clock rate
    localparam int LSR_CLK_KHZ = 10000;
    localparam int LSR_RDY_LOW_NS = 24000;
    localparam int LSR_RDY_LOW_CYC = (LSR_RDY_LOW_NS * LSR_CLK_KHZ) / 1000000;
    localparam logic [7:0] LSR_RDY_LAST = 8'(LSR_RDY_LOW_CYC - 1);

    // Conversion-ready pin state
    typedef enum logic [0:0] {
        LSR_RDY_IDLE = 1'b0,
        LSR_RDY_HOLD = 1'b1
    } lsr_rdy_state_t;
endpackage
`default_nettype wire

//--- src/lsr_edge_counter.sv
// Purpose: Rolling counter of rising edges of the debounced input level, or of its falling edges when inverted.
// Assumes: Level is already debounced and synchronous to clk.
// Notes: Previous level tracks even while disabled, so enabling never counts stale edges.
`default_nettype none
module lsr_edge_counter #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Counted input and its controls
    input wire logic level,
    input wire logic invert,
    input wire logic count_en,
    // Count
    output logic [CNT_W-1:0] count
);
    typedef struct packed {
        logic prev;
        logic [CNT_W-1:0] cnt;
    } lsr_cnt_state_t;

    lsr_cnt_state_t s_q;
    lsr_cnt_state_t s_d;
    logic shaped;

    // Optional inversion moves the counted edge to the falling side
    assign shaped = level ^ invert;

    // Next state: count rising edges only while enabled, freeze otherwise
    always_comb begin
        s_d = s_q;
        s_d.prev = shaped;
        if (count_en && shaped && !s_q.prev) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count = s_q.cnt;
endmodule
`default_nettype wire

//--- src/lsr_regs.sv
// Purpose: Live status word, conversion results, diagnostic results and input edge
//          counter, read by the serial port front end.
// Assumes: The serial front end turns frames into one-cycle read and write strobes.
// Notes: Read data appears one cycle after the read strobe.
//
// Contract
// - Condition bits follow their inputs directly, never latched; ready and busy bits come from registers.
// - Bit 14 analog open, bit 13 analog short, bit 15 zero.
// - Output short bits 10, 9 held low in initial window; 12:11 zero.
// - Bit 7 input open, bit 6 input short, thermal reset live.
// - Temperature bit set when die temperature is at or above 115 C.
// - Ready pin low on result, high 24 us later in continuous mode, else once ready bit clears; ready bit until written 1.
// - Busy bit resets to one, then follows the converter busy state.
// - Supply bit shows any supply alert status bit set.
// - First result at 0x44, second at 0x46, read-only, reset zero.
// - Four read-only diagnostic results at 0x53 to 0x56, reset zero.
// - Counter at 0x57 counts only while enabled, frozen otherwise.
// - Counter wraps from full scale to zero, no flag.
// - Invert bit inverts the debounced level before the counter.
// - Counted signal is the debounced threshold comparison result.
`default_nettype none
module lsr_regs #(
    parameter int RES_W = 16,
    parameter int DIAG_N = 4,
    parameter int TEMP_W = 9,
    parameter int SUPPLY_W = 7,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,

    // Register access from the serial front end
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,

    // Live conditions from the analog and output stages
    input wire logic analog_open_live,
    input wire logic analog_short_live,
    input wire logic out_internal_short_live,
    input wire logic out_external_short_live,
    input wire logic initial_short_window,
    input wire logic out_thermal_reset_live,
    input wire logic input_open_live,
    input wire logic input_short_live,
    input wire logic signed [TEMP_W-1:0] die_temp_c,
    input wire logic [SUPPLY_W-1:0] supply_alert_bits,
    input wire logic conv_busy,

    // Conversion results
    input wire logic continuous_mode,
    input wire logic result_valid,
    input wire logic result_slot,
    input wire logic [RES_W-1:0] result_data,
    input wire logic diag_valid,
    input wire logic [1:0] diag_index,
    input wire logic [RES_W-1:0] diag_data,

    // Digital input counting
    input wire logic din_level,
    input wire logic count_en,
    input wire logic comparator_invert_bit,

    // Conversion-ready pin, active low
    output logic conv_ready_n
);
    // State of the register group, apart from the edge counter
    typedef struct packed {
        logic [RES_W-1:0] first_result_value;
        logic [RES_W-1:0] second_result_value;
        logic [DIAG_N-1:0][RES_W-1:0] diag;
        logic data_rdy;
        logic busy;
        lsr_pkg::lsr_rdy_state_t rdy_state;
        logic [7:0] rdy_cnt;
        logic rdy_n;
        logic [15:0] rdata;
        logic rvalid;
    } lsr_state_t;

    lsr_state_t s_q;
    lsr_state_t s_d;
    logic [15:0] live_word;
    logic [CNT_W-1:0] edge_count_value;
    logic temp_high;
    logic rdy_clear;

    // Address decode for the live word, shared by reads and writes
    function automatic logic lsr_hit_live(input logic [7:0] a);
        return a == lsr_pkg::LSR_ADDR_LIVE;
    endfunction

    // Diagnostic window decode
    function automatic logic lsr_hit_diag(input logic [7:0] a);
        return (a >= lsr_pkg::LSR_ADDR_DIAG0) && (a <= lsr_pkg::LSR_ADDR_DIAG3);
    endfunction

    // Counter of the debounced, optionally inverted comparator level
    lsr_edge_counter #(
        .CNT_W(CNT_W)
    ) u_edge_counter (
        .clk(clk),
        .rst(rst),
        .level(din_level),
        .invert(comparator_invert_bit),
        .count_en(count_en),
        .count(edge_count_value)
    );

    // Temperature compare on the signed reading
    assign temp_high = die_temp_c >= TEMP_W'(lsr_pkg::LSR_TEMP_HIGH_C);

    // Write 1 to the ready bit clears it
    assign rdy_clear = reg_wr && lsr_hit_live(reg_addr)
                       && reg_wdata[lsr_pkg::LSR_BIT_DATA_RDY];

    // Condition bits are built straight from the inputs so each drops with its cause; ready and busy bits come from state
    always_comb begin
        live_word = 16'h0000;
        live_word[lsr_pkg::LSR_BIT_ANA_OPEN] = analog_open_live;
        live_word[lsr_pkg::LSR_BIT_ANA_SHORT] = analog_short_live;
        // Short alarms are not trusted while the switch is still in its window
        live_word[lsr_pkg::LSR_BIT_OUT_INT_SHORT] =
            out_internal_short_live && !initial_short_window;
        live_word[lsr_pkg::LSR_BIT_OUT_EXT_SHORT] =
            out_external_short_live && !initial_short_window;
        live_word[lsr_pkg::LSR_BIT_OUT_THERM] = out_thermal_reset_live;
        live_word[lsr_pkg::LSR_BIT_IN_OPEN] = input_open_live;
        live_word[lsr_pkg::LSR_BIT_IN_SHORT] = input_short_live;
        live_word[lsr_pkg::LSR_BIT_TEMP] = temp_high;
        live_word[lsr_pkg::LSR_BIT_DATA_RDY] = s_q.data_rdy;
        live_word[lsr_pkg::LSR_BIT_BUSY] = s_q.busy;
        live_word[lsr_pkg::LSR_BIT_SUPPLY] = |supply_alert_bits;
    end

    // Next state of results, ready flag, ready pin and read port
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;

        // Busy mirror, registered one cycle behind the input; reset loads one
        s_d.busy = conv_busy;

        // Result capture; host writes never reach these words
        if (result_valid && !result_slot) begin
            s_d.first_result_value = result_data;
        end
        if (result_valid && result_slot) begin
            s_d.second_result_value = result_data;
        end
        if (diag_valid) begin
            s_d.diag[diag_index] = diag_data;
        end

        // Ready flag: a new result in the clearing cycle keeps it set
        if (rdy_clear) begin
            s_d.data_rdy = 1'b0;
        end
        if (result_valid) begin
            s_d.data_rdy = 1'b1;
        end

        // Ready pin: low on each result, back high after the fixed time in continuous mode, else once the flag clears
        case (s_q.rdy_state)
            lsr_pkg::LSR_RDY_IDLE: begin
                s_d.rdy_n = 1'b1;
                if (result_valid) begin
                    s_d.rdy_state = lsr_pkg::LSR_RDY_HOLD;
                    s_d.rdy_cnt = 8'h00;
                    s_d.rdy_n = 1'b0;
                end
            end
            lsr_pkg::LSR_RDY_HOLD: begin
                s_d.rdy_n = 1'b0;
                if (result_valid) begin
                    // A fresh result restarts the low time
                    s_d.rdy_cnt = 8'h00;
                end else if (continuous_mode) begin
                    if (s_q.rdy_cnt == lsr_pkg::LSR_RDY_LAST) begin
                        s_d.rdy_state = lsr_pkg::LSR_RDY_IDLE;
                        s_d.rdy_n = 1'b1;
                    end else begin
                        s_d.rdy_cnt = s_q.rdy_cnt + 8'h01;
                    end
                end else if (!s_d.data_rdy) begin
                    // Single conversions hold the pin until the flag is cleared
                    s_d.rdy_state = lsr_pkg::LSR_RDY_IDLE;
                    s_d.rdy_n = 1'b1;
                end
            end
            default: begin
                s_d.rdy_state = lsr_pkg::LSR_RDY_IDLE;
                s_d.rdy_n = 1'b1;
            end
        endcase

        // Read port; unmapped indices answer zero
        if (reg_rd) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = 16'h0000;
            if (lsr_hit_live(reg_addr)) begin
                s_d.rdata = live_word;
            end else if (reg_addr == lsr_pkg::LSR_ADDR_RES1) begin
                s_d.rdata = s_q.first_result_value;
            end else if (reg_addr == lsr_pkg::LSR_ADDR_RES2) begin
                s_d.rdata = s_q.second_result_value;
            end else if (lsr_hit_diag(reg_addr)) begin
                s_d.rdata = s_q.diag[2'(reg_addr - lsr_pkg::LSR_ADDR_DIAG0)];
            end else if (reg_addr == lsr_pkg::LSR_ADDR_COUNT) begin
                s_d.rdata = 16'(edge_count_value);
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q.first_result_value <= lsr_pkg::LSR_RESULT_RESET;
            s_q.second_result_value <= lsr_pkg::LSR_RESULT_RESET;
            s_q.diag <= '0;
            s_q.data_rdy <= 1'b0;
            s_q.busy <= lsr_pkg::LSR_BUSY_RESET;
            s_q.rdy_state <= lsr_pkg::LSR_RDY_IDLE;
            s_q.rdy_cnt <= 8'h00;
            s_q.rdy_n <= 1'b1;
            s_q.rdata <= 16'h0000;
            s_q.rvalid <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;
    assign conv_ready_n = s_q.rdy_n;
endmodule
`default_nettype wire

//--- bench/lsr_regs_asserts.sv
// Purpose: Port assertions for the live status and result registers.
// Assumes: One clock domain, reset active high.
// Notes: Bound onto every lsr_regs instance.
`default_nettype none
module lsr_regs_chk #(
    parameter int TEMP_W = 9,
    parameter int SUPPLY_W = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register strobes
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // Conditions and results
    input wire logic initial_short_window,
    input wire logic signed [TEMP_W-1:0] die_temp_c,
    input wire logic [SUPPLY_W-1:0] supply_alert_bits,
    input wire logic conv_busy,
    input wire logic continuous_mode,
    input wire logic result_valid,
    input wire logic diag_valid,
    input wire logic conv_ready_n
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Read of the live word
    wire logic lv = reg_rd && (reg_addr == lsr_pkg::LSR_ADDR_LIVE);

    AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
        else $error("read without answer");
    AST_RD_IDLE: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    AST_RSVD: assert property (lv |=> (reg_rdata & 16'h9821) == 16'h0000)
        else $error("reserved live bit set");
    AST_SHORT_WIN: assert property (lv && initial_short_window
        |=> reg_rdata[10:9] == 2'b00)
        else $error("short bit inside initial window");
    AST_TEMP: assert property (lv |=> reg_rdata[4] == ($past(die_temp_c) >= 115))
        else $error("temperature bit wrong");
    AST_SUPPLY: assert property (lv |=> reg_rdata[1] == (|$past(supply_alert_bits)))
        else $error("supply bit wrong");
    AST_BUSY: assert property (lv |=> reg_rdata[2] == $past(conv_busy, 2))
        else $error("busy bit wrong");
    AST_RDY_HOLD: assert property (continuous_mode && result_valid
        |=> !conv_ready_n [*8])
        else $error("ready pin not held low");
    // Rise is seen 241 edges after the result edge: 240 low cycles, then the high sample
    AST_RDY_RISE: assert property ($rose(conv_ready_n) && continuous_mode
        |-> $past(result_valid, 241))
        else $error("ready pin rose at wrong time");
    // A diagnostic result alone never pulls the idle pin low
    AST_DIAG_PIN: assert property (diag_valid && !result_valid && conv_ready_n
        |=> conv_ready_n)
        else $error("ready pin fell on diagnostic result");
endmodule
bind lsr_regs lsr_regs_chk #(.TEMP_W(TEMP_W), .SUPPLY_W(SUPPLY_W)) u_lsr_regs_chk (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .initial_short_window(initial_short_window),
    .die_temp_c(die_temp_c),
    .supply_alert_bits(supply_alert_bits),
    .conv_busy(conv_busy),
    .continuous_mode(continuous_mode),
    .result_valid(result_valid),
    .diag_valid(diag_valid),
    .conv_ready_n(conv_ready_n)
);
`default_nettype wire

//--- bench/lsr_host.sv
// Purpose: Host model issuing register strobes.
// Assumes: One strobe per access, answer one cycle later.
// Notes: Released write data is inverted so stale values never match.
`default_nettype none
module lsr_host (
    // Clock
    input wire logic clk,
    // Strobe port
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
    end
    // One access: a one-cycle strobe, then the answer taken at the following edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                          output logic [15:0] rd);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= !wr;
        reg_wr <= wr;
        reg_wdata <= wd;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        reg_wdata <= ~wd;
        // Answer stands for the cycle after the strobe; take it at the edge that samples it
        @(posedge clk);
        rd = reg_rvalid ? reg_rdata : 16'hXXXX;
    endtask
endmodule
`default_nettype wire

//--- bench/tb_live_status_and_result_regs.sv
// Purpose: Self-checking bench for the live status and result registers.
// Assumes: 10 MHz clock, host model drives the strobes.
// Notes: The design's counter is cut to 4 bits so its wrap shows in few cycles.
`default_nettype none
module tb_live_status_and_result_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr;
    logic reg_rd, reg_wr, reg_rvalid, conv_ready_n;
    logic [15:0] reg_wdata, reg_rdata, rv, result_data, diag_data;
    logic analog_open_live, analog_short_live, out_internal_short_live;
    logic out_external_short_live, initial_short_window, out_thermal_reset_live;
    logic input_open_live, input_short_live, conv_busy, continuous_mode;
    logic signed [8:0] die_temp_c;
    logic [6:0] supply_alert_bits;
    logic result_valid, result_slot, diag_valid, din_level, count_en, comparator_invert_bit;
    logic [1:0] diag_index;
    int error_cnt = 0;
    int tests_run = 0;
    int n;

    // Narrow counter keeps the wrap test short
    lsr_regs #(.CNT_W(4)) u_lsr_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .analog_open_live(analog_open_live),
        .analog_short_live(analog_short_live),
        .out_internal_short_live(out_internal_short_live),
        .out_external_short_live(out_external_short_live),
        .initial_short_window(initial_short_window),
        .out_thermal_reset_live(out_thermal_reset_live), .input_open_live(input_open_live),
        .input_short_live(input_short_live), .die_temp_c(die_temp_c),
        .supply_alert_bits(supply_alert_bits), .conv_busy(conv_busy),
        .continuous_mode(continuous_mode), .result_valid(result_valid),
        .result_slot(result_slot), .result_data(result_data), .diag_valid(diag_valid),
        .diag_index(diag_index), .diag_data(diag_data), .din_level(din_level),
        .count_en(count_en), .comparator_invert_bit(comparator_invert_bit),
        .conv_ready_n(conv_ready_n));
    lsr_host u_lsr_host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    always #50 clk = ~clk;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        u_lsr_host.access(1'b0, a, 16'h0000, rv);
        check(rv, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_lsr_host.access(1'b1, a, d, rv);
    endtask
    // Result or diagnostic capture pulse
    task automatic res(input logic v, input logic sl, input logic [1:0] ix, input logic [15:0] d);
        @(posedge clk);
        result_valid <= v;
        diag_valid <= !v;
        result_slot <= sl;
        diag_index <= ix;
        result_data <= d;
        diag_data <= d;
        @(posedge clk);
        result_valid <= 1'b0;
        diag_valid <= 1'b0;
    endtask
    // k debounced input pulses, one high cycle each
    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge clk);
            din_level <= 1'b1;
            @(posedge clk);
            din_level <= 1'b0;
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run is under 2000 cycles
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end

    initial begin
        {analog_open_live, analog_short_live, out_internal_short_live} = 3'h0;
        {out_external_short_live, initial_short_window, out_thermal_reset_live} = 3'h0;
        {input_open_live, input_short_live, continuous_mode, conv_busy} = 4'h1;
        {die_temp_c, supply_alert_bits, result_valid, result_slot, diag_valid} = 19'h00000;
        {diag_index, result_data, diag_data} = 34'h000000000;
        {din_level, count_en, comparator_invert_bit} = 3'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'h42, 16'h0004);
        wr(8'h44, 16'hFFFF);
        rd_chk(8'h44, 16'h0000);
        rd_chk(8'h46, 16'h0000);
        for (int i = 0; i < 4; i++) rd_chk(8'h53 + 8'(i), 16'h0000);
        rd_chk(8'h57, 16'h0000);
        rd_chk(8'h50, 16'h0000);
        @(posedge clk);
        {analog_open_live, analog_short_live, out_internal_short_live} <= 3'h7;
        {out_external_short_live, initial_short_window, out_thermal_reset_live} <= 3'h7;
        {input_open_live, input_short_live, conv_busy} <= 3'h6;
        die_temp_c <= 9'h073;
        supply_alert_bits <= 7'h40;
        rd_chk(8'h42, 16'h61D2);
        initial_short_window <= 1'b0;
        rd_chk(8'h42, 16'h67D2);
        {analog_open_live, analog_short_live, out_internal_short_live} <= 3'h0;
        {out_external_short_live, out_thermal_reset_live, input_open_live} <= 3'h0;
        {input_short_live, supply_alert_bits} <= 8'h00;
        die_temp_c <= 9'h072;
        wr(8'h42, 16'hFFFF);
        rd_chk(8'h42, 16'h0000);
        // Diagnostics first, while the ready pin is idle
        for (int i = 0; i < 4; i++) res(1'b0, 1'b0, 2'(i), 16'hD000 + 16'(i));
        res(1'b1, 1'b0, 2'h0, 16'h1234);
        res(1'b1, 1'b1, 2'h0, 16'hABCD);
        rd_chk(8'h44, 16'h1234);
        rd_chk(8'h46, 16'hABCD);
        for (int i = 0; i < 4; i++) rd_chk(8'h53 + 8'(i), 16'hD000 + 16'(i));
        rd_chk(8'h42, 16'h0008);
        check({15'h0000, conv_ready_n}, 16'h0000);
        wr(8'h42, 16'h0008);
        check({15'h0000, conv_ready_n}, 16'h0001);
        rd_chk(8'h42, 16'h0000);
        continuous_mode <= 1'b1;
        res(1'b1, 1'b0, 2'h0, 16'h0F0F);
        n = 0;
        repeat (300) begin
            #1;
            if (conv_ready_n !== 1'b0) break;
            n++;
            @(posedge clk);
        end
        check(16'(n), 16'h00F0);
        rd_chk(8'h42, 16'h0008);
        continuous_mode <= 1'b0;
        wr(8'h42, 16'h0008);
        count_en <= 1'b1;
        pulse(3);
        rd_chk(8'h57, 16'h0003);
        @(posedge clk);
        comparator_invert_bit <= 1'b1;
        pulse(1);
        @(posedge clk);
        comparator_invert_bit <= 1'b0;
        rd_chk(8'h57, 16'h0005);
        count_en <= 1'b0;
        pulse(2);
        rd_chk(8'h57, 16'h0005);
        count_en <= 1'b1;
        pulse(11);
        rd_chk(8'h57, 16'h0000);
        pulse(1);
        rd_chk(8'h57, 16'h0001);
        conclude();
    end
endmodule
`default_nettype wire
